/* File: src/sar_adc_pkg.sv */
// Package: register map, field layout, cycle counts and carrier types for the converter
package sar_adc_pkg;
  // Byte offsets of the register port
  localparam logic [7:0] ADDR_RESULT_BASE = 8'h00;
  localparam logic [7:0] ADDR_RESULT_LAST = 8'h0F;
  localparam logic [7:0] ADDR_CTRL0 = 8'h10;
  localparam logic [7:0] ADDR_CTRL1 = 8'h11;
  localparam logic [7:0] ADDR_STATUS = 8'h12;
  // Control 0 field positions
  localparam int CTRL0_SEL_LSB = 0;
  localparam int CTRL0_MODE_LSB = 3;
  localparam int CTRL0_EXT_BIT = 6;
  localparam int CTRL0_START_BIT = 7;
  // Control 1 field positions
  localparam int CTRL1_GRP_LSB = 0;
  localparam int CTRL1_RES10_BIT = 2;
  localparam int CTRL1_DIV_LSB = 3;
  localparam int CTRL1_VREF_BIT = 5;
  localparam int CTRL1_SH_BIT = 6;
  // Values after reset
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  // Converter clock divider choices
  localparam logic [1:0] DIV_4 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_1 = 2'h2;
  // Converter clock cycles per pin: 49, 59, 28, 33
  localparam logic [5:0] CYC_8_PLAIN = 6'h31;
  localparam logic [5:0] CYC_10_PLAIN = 6'h3B;
  localparam logic [5:0] CYC_8_SH = 6'h1C;
  localparam logic [5:0] CYC_10_SH = 6'h21;
  // Bits resolved per conversion
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_10 = 4'hA;
  localparam logic [9:0] DAC_MSB = 10'h200;
  localparam logic [2:0] LAST_CH = 3'h7;
  typedef enum logic [2:0] {
    MODE_ONE_SHOT = 3'h0,
    MODE_REPEAT = 3'h1,
    MODE_SINGLE_SWEEP = 3'h2,
    MODE_REP_SWEEP0 = 3'h3,
    MODE_REP_SWEEP1 = 3'h4
  } conv_mode_t;
  typedef struct packed {
    logic res10;
    logic sample_hold;
  } conv_cfg_t;
  typedef struct packed {
    logic done;
    logic [9:0] data;
  } conv_result_t;
endpackage

/* File: src/trig_edge_sync.sv */
// Two-stage synchroniser with falling-edge detector for the external trigger
`timescale 1ns/1ps
module trig_edge_sync
  import sar_adc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic pin_in,
  output logic fall_out
);
  logic meta;
  logic sync;
  logic prev;

  // Idle level of the trigger is high, so reset to one avoids a false edge
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
    end
  end

  // One pulse per high-to-low change, only the second stage is looked at
  assign fall_out = prev & ~sync;
endmodule

/* File: src/sar_core.sv */
// Successive-approximation engine: sample phase then one bit trial per converter tick
`timescale 1ns/1ps
module sar_core
  import sar_adc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic tick_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire conv_cfg_t cfg_in,
  input wire logic comp_in,
  output conv_result_t result_out,
  output logic [9:0] dac_code_out,
  output logic busy_out,
  output logic sampling_out
);
  logic [5:0] cnt;
  logic [3:0] bit_idx;
  logic [5:0] total;
  logic [5:0] trial_start;

  // Conversion length picked from resolution and sample-and-hold
  always_comb begin
    if (cfg_in.res10) begin
      total = cfg_in.sample_hold ? CYC_10_SH : CYC_10_PLAIN;
    end else begin
      total = cfg_in.sample_hold ? CYC_8_SH : CYC_8_PLAIN;
    end
    trial_start = total - 6'(cfg_in.res10 ? BITS_10 : BITS_8);
  end

  // Counter, trial code and bit decisions; one shared comparator for all inputs
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      busy_out <= 1'b0;
      cnt <= 6'h00;
      bit_idx <= 4'h0;
      dac_code_out <= 10'h000;
      result_out <= '0;
    end else begin
      result_out.done <= 1'b0;
      if (abort_in) begin
        busy_out <= 1'b0;
      end else if (start_in) begin
        busy_out <= 1'b1;
        cnt <= 6'h00;
        dac_code_out <= 10'h000;
      end else if (busy_out && tick_in) begin
        cnt <= cnt + 6'h01;
        if (cnt == trial_start - 6'h01) begin
          dac_code_out <= DAC_MSB;
          bit_idx <= 4'h9;
        end else if (cnt >= trial_start) begin
          if (!comp_in) begin
            dac_code_out[bit_idx] <= 1'b0;
          end
          if (cnt != total - 6'h01) begin
            dac_code_out[bit_idx - 4'h1] <= 1'b1;
            bit_idx <= bit_idx - 4'h1;
          end else begin
            // Final decision: 8-bit results drop the two unused low trials
            busy_out <= 1'b0;
            result_out.done <= 1'b1;
            result_out.data <= cfg_in.res10 ?
                {dac_code_out[9:1], comp_in} : {2'h0, dac_code_out[9:3], comp_in};
          end
        end
      end
    end
  end

  assign sampling_out = busy_out && (cnt < trial_start);
endmodule

/* File: src/sar_adc_sequencer.sv */
// Converter sequencer: register port, clock divider, start logic, modes and result store
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic ext_conv_trigger_in,
  input wire logic low_supply_in,
  input wire logic comp_in,
  output logic vref_connect_out,
  output logic [2:0] analog_input_n_sel_out,
  output logic [9:0] dac_code_out,
  output logic sampling_out,
  output logic conv_irq_out
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_CONV = 2'b10
  } seq_state_t;

  seq_state_t state;
  logic [2:0] pin_sel;
  conv_mode_t mode;
  logic ext_trig;
  logic start_flag;
  logic [1:0] grp;
  logic res10;
  logic [1:0] div_sel;
  logic sample_hold;
  logic [1:0] div_cnt;
  logic [1:0] eff_div;
  logic tick;
  logic trig_fall;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic sw_launch;
  logic ext_launch;
  logic launch;
  logic stop;
  logic finish;
  logic restart;
  logic [2:0] cur_ch;
  logic [2:0] grp_last;
  logic [2:0] emph_ch;
  logic [2:0] oth_ch;
  logic on_emph;
  logic [2:0] first_ch;
  conv_mode_t new_mode;
  logic [7:0] res_lo [8];
  logic [1:0] res_hi [8];
  logic sar_busy;
  conv_cfg_t cfg;
  conv_result_t sar_res;

  assign wr_ctrl0 = reg_wr_in && (reg_addr_in == ADDR_CTRL0);
  assign wr_ctrl1 = reg_wr_in && (reg_addr_in == ADDR_CTRL1);
  assign new_mode = wr_ctrl0 ? conv_mode_t'(reg_wdata_in[CTRL0_MODE_LSB +: 3]) : mode;
  assign cfg = '{res10: res10, sample_hold: sample_hold};
  assign grp_last = {grp, 1'b1};
  assign analog_input_n_sel_out = cur_ch;

  // Control register 0: input select, mode, trigger source
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pin_sel <= CTRL0_RESET[CTRL0_SEL_LSB +: 3];
      mode <= conv_mode_t'(CTRL0_RESET[CTRL0_MODE_LSB +: 3]);
      ext_trig <= CTRL0_RESET[CTRL0_EXT_BIT];
    end else if (wr_ctrl0) begin
      pin_sel <= reg_wdata_in[CTRL0_SEL_LSB +: 3];
      mode <= conv_mode_t'(reg_wdata_in[CTRL0_MODE_LSB +: 3]);
      ext_trig <= reg_wdata_in[CTRL0_EXT_BIT];
    end
  end

  // Start flag: a software write wins over the hardware clear in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      start_flag <= CTRL0_RESET[CTRL0_START_BIT];
    end else if (wr_ctrl0) begin
      start_flag <= reg_wdata_in[CTRL0_START_BIT];
    end else if (finish && !ext_trig) begin
      start_flag <= 1'b0;
    end
  end

  // Control register 1: group, resolution, divider, reference, hold
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      grp <= CTRL1_RESET[CTRL1_GRP_LSB +: 2];
      res10 <= CTRL1_RESET[CTRL1_RES10_BIT];
      div_sel <= CTRL1_RESET[CTRL1_DIV_LSB +: 2];
      vref_connect_out <= CTRL1_RESET[CTRL1_VREF_BIT];
      sample_hold <= CTRL1_RESET[CTRL1_SH_BIT];
    end else if (wr_ctrl1) begin
      grp <= reg_wdata_in[CTRL1_GRP_LSB +: 2];
      res10 <= reg_wdata_in[CTRL1_RES10_BIT];
      div_sel <= reg_wdata_in[CTRL1_DIV_LSB +: 2];
      vref_connect_out <= reg_wdata_in[CTRL1_VREF_BIT];
      sample_hold <= reg_wdata_in[CTRL1_SH_BIT];
    end
  end

  // Converter tick; at low supply the undivided clock is too fast, so force divide-by-2
  always_comb begin
    eff_div = div_sel;
    if (low_supply_in && div_sel == DIV_1) begin
      eff_div = DIV_2;
    end
    case (eff_div)
      DIV_1: tick = 1'b1;
      DIV_2: tick = div_cnt[0];
      default: tick = (div_cnt == 2'h3);
    endcase
  end

  // Free-running prescaler on the oscillator clock
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  trig_edge_sync u_trig (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .pin_in(ext_conv_trigger_in),
    .fall_out(trig_fall)
  );

  // Launch and stop decode; an external edge mid-conversion restarts the sequence
  assign stop = wr_ctrl0 && !reg_wdata_in[CTRL0_START_BIT];
  assign sw_launch = wr_ctrl0 && reg_wdata_in[CTRL0_START_BIT] && !start_flag
      && !reg_wdata_in[CTRL0_EXT_BIT];
  assign ext_launch = start_flag && ext_trig && trig_fall && !wr_ctrl0;
  assign launch = sw_launch || ext_launch;

  // First pin: selected pin, or pin 0 in sweeps; a start write must use its own fields
  assign first_ch = (new_mode inside {MODE_SINGLE_SWEEP, MODE_REP_SWEEP0, MODE_REP_SWEEP1}) ? 3'h0
      : (wr_ctrl0 ? reg_wdata_in[CTRL0_SEL_LSB +: 3] : pin_sel);

  // End-of-pin decision per mode
  always_comb begin
    finish = 1'b0;
    restart = 1'b0;
    if (state == S_CONV && sar_res.done) begin
      case (mode)
        MODE_REPEAT, MODE_REP_SWEEP0, MODE_REP_SWEEP1: restart = 1'b1;
        MODE_SINGLE_SWEEP: begin
          finish = (cur_ch == grp_last);
          restart = !finish;
        end
        default: finish = 1'b1;
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: if (launch) state <= S_CONV;
        S_CONV: if (stop || finish) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Pin stepping; sweep 1 alternates an emphasis pin with the remaining pins
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      cur_ch <= 3'h0;
      emph_ch <= 3'h0;
      oth_ch <= 3'h1;
      on_emph <= 1'b1;
    end else if (launch) begin
      cur_ch <= first_ch;
      emph_ch <= 3'h0;
      oth_ch <= grp_last;
      on_emph <= 1'b1;
      if (new_mode == MODE_REP_SWEEP1) begin
        oth_ch <= {1'b0, grp} + 3'h1;
      end
    end else if (restart) begin
      case (mode)
        MODE_SINGLE_SWEEP, MODE_REP_SWEEP0: begin
          cur_ch <= (cur_ch == grp_last) ? 3'h0 : cur_ch + 3'h1;
        end
        MODE_REP_SWEEP1: begin
          if (on_emph) begin
            cur_ch <= oth_ch;
            emph_ch <= (emph_ch == {1'b0, grp}) ? 3'h0 : emph_ch + 3'h1;
          end else begin
            cur_ch <= emph_ch;
            oth_ch <= (oth_ch == LAST_CH) ? {1'b0, grp} + 3'h1 : oth_ch + 3'h1;
          end
          on_emph <= !on_emph;
        end
        default: cur_ch <= cur_ch;
      endcase
    end
  end

  sar_core u_sar (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .tick_in(tick),
    .start_in(launch || restart),
    .abort_in(stop),
    .cfg_in(cfg),
    .comp_in(comp_in),
    .result_out(sar_res),
    .dac_code_out(dac_code_out),
    .busy_out(sar_busy),
    .sampling_out(sampling_out)
  );

  // Result store: even byte low bits, odd byte top two only at ten bits
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 8; i++) begin
        res_lo[i] <= 8'h00;
        res_hi[i] <= 2'h0;
      end
    end else if (state == S_CONV && sar_res.done) begin
      res_lo[cur_ch] <= sar_res.data[7:0];
      if (res10) begin
        res_hi[cur_ch] <= sar_res.data[9:8];
      end
    end
  end

  // Request pulse at the end of one-shot and single sweep
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      conv_irq_out <= 1'b0;
    end else begin
      conv_irq_out <= finish;
    end
  end

  // Read port; unmapped addresses and strobe-free cycles read zero
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_addr_in <= ADDR_RESULT_LAST) begin
      reg_rdata_out <= reg_addr_in[0] ? {6'h00, res_hi[reg_addr_in[3:1]]}
          : res_lo[reg_addr_in[3:1]];
    end else begin
      case (reg_addr_in)
        ADDR_CTRL0: reg_rdata_out <= {start_flag, ext_trig, mode, pin_sel};
        ADDR_CTRL1: reg_rdata_out <= {1'b0, sample_hold, vref_connect_out, div_sel, res10, grp};
        ADDR_STATUS: reg_rdata_out <= {3'h0, low_supply_in, cur_ch, sar_busy};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Helper: ticks spent by the engine on the current pin
  logic [5:0] tick_cnt;
  logic [5:0] exp_total;
  assign exp_total = res10 ? (sample_hold ? CYC_10_SH : CYC_10_PLAIN)
      : (sample_hold ? CYC_8_SH : CYC_8_PLAIN);
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || launch || restart) begin
      tick_cnt <= 6'h00;
    end else if (sar_busy && tick) begin
      tick_cnt <= tick_cnt + 6'h01;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_vref;
    wr_ctrl1 |=> vref_connect_out == $past(reg_wdata_in[CTRL1_VREF_BIT]);
  endproperty
  a_vref: assert property (p_vref) else $error("reference bit not applied");

  property p_sw_start;
    sw_launch |=> sar_busy && state == S_CONV;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start lost");

  property p_ext_start;
    ext_launch |=> sar_busy ##0 cur_ch == $past(first_ch);
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("trigger start lost");

  property p_one_shot;
    (state == S_CONV && sar_res.done && mode == MODE_ONE_SHOT && !wr_ctrl0)
        |=> conv_irq_out && state == S_IDLE && (start_flag == $past(ext_trig));
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot end wrong");

  property p_repeat_quiet;
    mode == MODE_REPEAT && $past(mode) == MODE_REPEAT |-> !conv_irq_out;
  endproperty
  a_repeat_quiet: assert property (p_repeat_quiet) else $error("repeat raised request");

  property p_store;
    (state == S_CONV && sar_res.done) |=> res_lo[$past(cur_ch)] == $past(sar_res.data[7:0]);
  endproperty
  a_store: assert property (p_store) else $error("result not stored");

  property p_eight_bit;
    sar_res.done && !res10 |=> res_hi[$past(cur_ch)] == $past(res_hi[cur_ch]);
  endproperty
  a_eight_bit: assert property (p_eight_bit) else $error("odd byte touched at 8 bits");

  property p_length;
    sar_res.done && !$past(launch || restart || stop) |-> tick_cnt == exp_total;
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong");

  property p_low_supply;
    low_supply_in && tick ##1 low_supply_in |-> !tick;
  endproperty
  a_low_supply: assert property (p_low_supply) else $error("undivided clock at low supply");

  property p_group;
    state == S_CONV && (mode == MODE_SINGLE_SWEEP || mode == MODE_REP_SWEEP0)
        && !$past(launch) |-> cur_ch <= grp_last;
  endproperty
  a_group: assert property (p_group) else $error("sweep left its group");

  property p_one_edge;
    trig_fall |-> $past(ext_conv_trigger_in, 3) && !$past(ext_conv_trigger_in, 2);
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("trigger start without pin edge");

  c_one_shot: cover property (conv_irq_out && mode == MODE_ONE_SHOT);
  c_sweep1: cover property (restart && mode == MODE_REP_SWEEP1 && !on_emph);
  c_retrigger: cover property (ext_launch && sar_busy);
  c_ten_bit: cover property (sar_res.done && res10 && sample_hold);
endmodule

/* File: testbench/analog_front_model.sv */
// Far-side model: analogue input levels, comparator and external trigger pin
`timescale 1ns/1ps
module analog_front_model (
  input wire logic sys_clk_in,
  input wire logic vref_in,
  input wire logic [2:0] sel_in,
  input wire logic [9:0] dac_in,
  input wire logic trig_low_in,
  output logic comp_out,
  output logic trig_pin_out
);
  logic noise = 1'b0;

  // Fixed level per input pin; bits differ per pin so a wrong slot shows up
  function automatic logic [9:0] level(input logic [2:0] ch);
    return {ch, 7'h35};
  endfunction

  // A floating ladder gives no usable answer, so the comparator toggles
  always_ff @(posedge sys_clk_in) begin
    noise <= ~noise;
  end

  // Pins are held as inputs; the answer is ready at once
  assign comp_out = vref_in ? (level(sel_in) >= dac_in) : noise;

  // Trigger line idles high and is pulled low on request
  assign trig_pin_out = ~trig_low_in;
endmodule

/* File: testbench/sar_adc_sequencer_tb_top.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_tb_top
  import sar_adc_pkg::*;
();
  localparam int LIMIT = 20000;
  logic sys_clk_in;
  logic rstn_in;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic ext_conv_trigger_in;
  logic low_supply_in;
  logic comp_in;
  logic vref_connect_out;
  logic [2:0] analog_input_n_sel_out;
  logic [9:0] dac_code_out;
  logic sampling_out;
  logic conv_irq_out;
  logic trig_low;
  logic samp_prev = 1'b0;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  sar_adc_sequencer u_sar_adc_sequencer (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .ext_conv_trigger_in(ext_conv_trigger_in),
    .low_supply_in(low_supply_in),
    .comp_in(comp_in),
    .vref_connect_out(vref_connect_out),
    .analog_input_n_sel_out(analog_input_n_sel_out),
    .dac_code_out(dac_code_out),
    .sampling_out(sampling_out),
    .conv_irq_out(conv_irq_out)
  );

  analog_front_model u_analog_front_model (
    .sys_clk_in(sys_clk_in),
    .vref_in(vref_connect_out),
    .sel_in(analog_input_n_sel_out),
    .dac_in(dac_code_out),
    .trig_low_in(trig_low),
    .comp_out(comp_in),
    .trig_pin_out(ext_conv_trigger_in)
  );

  // 20 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  // Previous sampling level for rise detection at the falling edge; run-length guard
  always @(posedge sys_clk_in) begin
    samp_prev <= sampling_out;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      $display("MISMATCH run length expected below %0d seen %0d", LIMIT, cycles);
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [9:0] lvl(input int ch);
    return u_analog_front_model.level(3'(ch));
  endfunction

  // Control 1 image; reference always connected before any start
  function automatic logic [7:0] cfg(input logic sh, input logic res10, input logic [1:0] div,
                                     input logic [1:0] grp);
    return {1'b0, sh, 1'b1, div, res10, grp};
  endfunction

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk_in);
    reg_addr_in <= addr;
    reg_wdata_in <= data;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk_in);
    reg_addr_in <= addr;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    data = reg_rdata_out;
  endtask

  task automatic watch(input int n, output int rises, output int irqs);
    rises = 0;
    irqs = 0;
    repeat (n) begin
      @(negedge sys_clk_in);
      if (sampling_out === 1'b1 && samp_prev !== 1'b1) rises++;
      if (conv_irq_out === 1'b1) irqs++;
    end
  endtask

  // One-shot software start; n counts cycles from the taking edge to the request
  task automatic conv_time(input logic [7:0] ctrl1, input logic [2:0] ch, output int n);
    reg_write(ADDR_CTRL1, ctrl1);
    reg_write(ADDR_CTRL0, {5'h10, ch});
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (conv_irq_out !== 1'b1 && n < 500);
    check("request raised", 16'h0001, 16'(conv_irq_out));
    @(negedge sys_clk_in);
    check("request one cycle", 16'h0000, 16'(conv_irq_out));
  endtask

  task automatic t_regs();
    logic [7:0] d;
    check("vref after reset", 16'h0000, 16'(vref_connect_out));
    reg_read(ADDR_CTRL0, d);
    check("ctrl0 reset", 16'(CTRL0_RESET), 16'(d));
    reg_read(ADDR_CTRL1, d);
    check("ctrl1 reset", 16'(CTRL1_RESET), 16'(d));
    reg_write(ADDR_STATUS, 8'hff);
    reg_write(ADDR_RESULT_BASE, 8'hff);
    reg_read(ADDR_STATUS, d);
    check("status read only", 16'h0000, 16'(d));
    reg_read(ADDR_RESULT_BASE, d);
    check("result read only", 16'h0000, 16'(d));
    reg_read(8'h20, d);
    check("unmapped read", 16'h0000, 16'(d));
    reg_write(ADDR_CTRL1, 8'h20);
    @(negedge sys_clk_in);
    check("vref on", 16'h0001, 16'(vref_connect_out));
    reg_write(ADDR_CTRL1, 8'h00);
    @(negedge sys_clk_in);
    check("vref off", 16'h0000, 16'(vref_connect_out));
  endtask

  // Every pin at ten bits, then one pin at eight bits
  task automatic t_results();
    int n;
    logic [7:0] d;
    logic [9:0] v;
    for (int ch = 0; ch < 8; ch++) begin
      v = lvl(ch);
      conv_time(cfg(1'b1, 1'b1, DIV_1, 2'h0), 3'(ch), n);
      reg_read(8'(2 * ch), d);
      check("even byte", 16'(v[7:0]), 16'(d));
      reg_read(8'(2 * ch + 1), d);
      check("odd byte", 16'(v[9:8]), 16'(d));
      reg_read(ADDR_CTRL0, d);
      check("flag cleared", 16'(ch), 16'(d));
    end
    v = lvl(2);
    conv_time(cfg(1'b1, 1'b0, DIV_1, 2'h0), 3'h2, n);
    reg_read(8'h04, d);
    check("eight-bit even", 16'(v[9:2]), 16'(d));
    reg_read(8'h05, d);
    check("eight-bit odd kept", 16'(v[9:8]), 16'(d));
  endtask

  task automatic t_timing();
    int a;
    int b;
    int c;
    int e;
    int s;
    logic [7:0] d;
    s = int'(CYC_8_SH);
    conv_time(cfg(1'b1, 1'b0, DIV_1, 2'h0), 3'h4, a);
    conv_time(cfg(1'b1, 1'b1, DIV_1, 2'h0), 3'h4, b);
    check("hold ten-bit length", 16'(CYC_10_SH - CYC_8_SH), 16'(b - a));
    conv_time(cfg(1'b0, 1'b0, DIV_1, 2'h0), 3'h4, c);
    check("plain eight-bit length", 16'(CYC_8_PLAIN - CYC_8_SH), 16'(c - a));
    conv_time(cfg(1'b0, 1'b1, DIV_1, 2'h0), 3'h4, c);
    check("plain ten-bit length", 16'(CYC_10_PLAIN - CYC_8_SH), 16'(c - a));
    conv_time(cfg(1'b1, 1'b0, DIV_2, 2'h0), 3'h4, e);
    check("divide by two", 16'h0001, 16'(e - a >= s - 2 && e - a <= s + 2));
    conv_time(cfg(1'b1, 1'b0, DIV_4, 2'h0), 3'h4, e);
    check("divide by four", 16'h0001, 16'(e - a >= 3 * s - 4 && e - a <= 3 * s + 4));
    @(posedge sys_clk_in);
    low_supply_in <= 1'b1;
    conv_time(cfg(1'b1, 1'b0, DIV_1, 2'h0), 3'h4, e);
    check("low supply divides", 16'h0001, 16'(e - a >= s - 2 && e - a <= s + 2));
    reg_read(ADDR_STATUS, d);
    check("status low supply", 16'h0001, 16'(d[4]));
    @(posedge sys_clk_in);
    low_supply_in <= 1'b0;
  endtask

  task automatic t_repeat();
    int r;
    int i;
    logic [7:0] d;
    logic [9:0] v;
    v = lvl(5);
    reg_write(ADDR_CTRL1, cfg(1'b1, 1'b0, DIV_1, 2'h0));
    reg_write(ADDR_CTRL0, {2'b10, MODE_REPEAT, 3'h5});
    watch(200, r, i);
    check("repeat restarts", 16'h0001, 16'(r >= 5));
    check("repeat no request", 16'h0000, 16'(i));
    reg_write(ADDR_CTRL0, 8'h00);
    watch(100, r, i);
    check("repeat stopped", 16'h0000, 16'(r));
    reg_read(ADDR_STATUS, d);
    check("idle after stop", 16'h0000, 16'(d[0]));
    reg_read(8'h0a, d);
    check("repeat result", 16'(v[9:2]), 16'(d));
  endtask

  function automatic logic [2:0] exp_pin(input conv_mode_t mode, input int grp, input int i);
    int ne;
    ne = grp + 1;
    if (mode == MODE_REP_SWEEP1) begin
      if (i % 2 == 0) return 3'((i / 2) % ne);
      return 3'(ne + (i / 2) % (8 - ne));
    end
    return 3'(i % (2 * grp + 2));
  endfunction

  // Pin order taken at each start of sampling
  task automatic sweep(input conv_mode_t mode, input int grp, input int count);
    int idx;
    int all;
    int irqs;
    idx = 0;
    all = 0;
    irqs = 0;
    reg_write(ADDR_CTRL1, cfg(1'b1, 1'b0, DIV_1, 2'(grp)));
    reg_write(ADDR_CTRL0, {2'b10, mode, 3'h0});
    repeat (30 * count + 40) begin
      @(negedge sys_clk_in);
      if (conv_irq_out === 1'b1) irqs++;
      if (sampling_out === 1'b1 && samp_prev !== 1'b1) begin
        if (idx < count) begin
          check("sweep pin", 16'(exp_pin(mode, grp, idx)), 16'(analog_input_n_sel_out));
          idx++;
        end
        all++;
      end
    end
    check("sweep pins seen", 16'(count), 16'(idx));
    if (mode == MODE_SINGLE_SWEEP) begin
      check("single sweep ends", 16'(count), 16'(all));
      check("single sweep request", 16'h0001, 16'(irqs));
    end else begin
      check("sweep no request", 16'h0000, 16'(irqs));
    end
    reg_write(ADDR_CTRL0, 8'h00);
  endtask

  // Pin high for four cycles, then a falling edge that stays low
  task automatic ext_fall();
    @(posedge sys_clk_in);
    trig_low <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    trig_low <= 1'b1;
  endtask

  task automatic t_ext();
    int r;
    int i;
    logic [7:0] d;
    reg_write(ADDR_CTRL1, cfg(1'b1, 1'b0, DIV_1, 2'h0));
    reg_write(ADDR_CTRL0, 8'hc1);
    watch(10, r, i);
    check("no start without edge", 16'h0000, 16'(r));
    ext_fall();
    watch(80, r, i);
    check("one start per edge", 16'h0001, 16'(r));
    check("external request", 16'h0001, 16'(i));
    reg_read(ADDR_CTRL0, d);
    check("flag kept", 16'h00c1, 16'(d));
    reg_write(ADDR_CTRL1, cfg(1'b1, 1'b0, DIV_4, 2'h0));
    ext_fall();
    watch(90, r, i);
    check("slow start", 16'h0001, 16'(r));
    check("slow not done", 16'h0000, 16'(i));
    ext_fall();
    watch(160, r, i);
    check("retrigger restarts", 16'h0001, 16'(r));
    check("one result after retrigger", 16'h0001, 16'(i));
    reg_write(ADDR_CTRL0, 8'h00);
  endtask

  initial begin
    rstn_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    low_supply_in = 1'b0;
    trig_low = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    @(posedge sys_clk_in);
    t_regs();
    t_results();
    t_timing();
    t_repeat();
    sweep(MODE_SINGLE_SWEEP, 1, 4);
    sweep(MODE_SINGLE_SWEEP, 3, 8);
    sweep(MODE_REP_SWEEP0, 0, 6);
    sweep(MODE_REP_SWEEP1, 0, 10);
    sweep(MODE_REP_SWEEP1, 2, 12);
    t_ext();
    summarize();
  end
endmodule
